// ===== src/ventricular_pacing_suppression.sv
// Purpose: Mode controller moving between DDD(R) pacing and ADI(R) with ventricular sensing only
// Assumes: All event inputs are one-cycle pulses synchronous to core_clk
// Notes:   Registers reached over APB with no wait states
//
// Decided for this implementation: the register addresses and register access over APB.
`include "vps_regs.svh"

module ventricular_pacing_suppression
  import vps_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_NS / `CLK_NS
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cycleEnd,
  input  wire logic        ventricularSensedEvent,
  input  wire logic        intrinsicAboveRate,
  input  wire logic [7:0]  rateBpm,
  input  wire logic        headRemoved,
  input  wire logic        modeSwitchMet,
  input  wire logic        resyncMet,
  input  wire logic        higherPrioritySuspend,
  input  wire logic        midnight,
  output logic             suppressionActive,
  output logic             ventricularPaceEnable,
  output logic             atrialPaceEnable,
  output logic      [9:0]  avDelayMs,
  output logic             ddiActive,
  output logic      [4:0]  modeState
);

  // Bus and configuration registers
  logic [31:0] ctrl_reg, ctrl_next;
  logic [9:0]  avProg_reg, avProg_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;

  // Controller state
  vps_state_t  state_reg, state_next;
  logic [14:0] pre_reg, pre_next;
  logic        msTick_reg, msTick_next;
  logic [31:0] waitTarget_reg, waitTarget_next;
  logic        vsFlag_reg, vsFlag_next;
  logic [3:0]  consec_reg, consec_next;
  logic [3:0]  searchCyc_reg, searchCyc_next;
  logic [1:0]  missRun_reg, missRun_next;
  logic [3:0]  switchCnt_reg, switchCnt_next;
  logic        lock_reg, lock_next;
  logic [15:0] failCnt_reg, failCnt_next;
  logic        fallback_reg, fallback_next;

  // Output registers
  logic        supp_reg, supp_next;
  logic        vPace_reg, vPace_next;
  logic        aPace_reg, aPace_next;
  logic [9:0]  avOut_reg, avOut_next;
  logic        ddi_reg, ddi_next;

  // Helpers
  logic        setup, wrEn, hit;
  logic [31:0] rdMux;
  logic        enabled, suspend, seen, fallbackNow, restart;
  logic        waitClr, gapClr, hourClr;
  logic [31:0] waitCnt;
  logic [21:0] gapCnt;
  logic [21:0] hourCnt;
  logic [9:0]  extAv, stepMul, avShort;
  logic [7:0]  rateDiff;
  logic [3:0]  vsNeeded;
  logic [3:0]  xNeeded;

  history_if hbus ();

  vps_cycle_history u_history (
    .core_clk (core_clk),
    .rst      (rst),
    .hist     (hbus)
  );

  vps_ms_counter #(.W(32)) u_wait (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (waitClr),
    .tick     (msTick_reg),
    .count    (waitCnt)
  );

  vps_ms_counter #(.W(22)) u_gap (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (gapClr),
    .tick     (msTick_reg),
    .count    (gapCnt)
  );

  vps_ms_counter #(.W(22)) u_hour (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (hourClr),
    .tick     (msTick_reg),
    .count    (hourCnt)
  );

  // APB slave, zero wait states
  always_comb begin
    setup = psel && !penable;
    wrEn  = psel && penable && pready_reg && pwrite;
    hit   = (paddr == `OFS_CTRL) || (paddr == `OFS_AVDELAY) || (paddr == `OFS_STATUS) ||
            (paddr == `OFS_SCHED) || (paddr == `OFS_COUNTS);
    case (paddr)
      `OFS_CTRL:    rdMux = ctrl_reg;
      `OFS_AVDELAY: rdMux = {22'h0, avProg_reg};
      `OFS_STATUS:  rdMux = {16'h0, hbus.missCount, 3'h0, lock_reg, 3'h0, state_reg};
      `OFS_SCHED:   rdMux = waitTarget_reg;
      `OFS_COUNTS:  rdMux = {failCnt_reg, 12'h0, switchCnt_reg};
      default:      rdMux = 32'h0000_0000;
    endcase
    pready_next  = setup;
    pslverr_next = setup && !hit;
    prdata_next  = (setup && !pwrite) ? rdMux : 32'h0000_0000;
    ctrl_next    = ctrl_reg;
    avProg_next  = avProg_reg;
    if (wrEn && (paddr == `OFS_CTRL)) begin
      ctrl_next = pwdata & `CTRL_WMASK;
    end
    if (wrEn && (paddr == `OFS_AVDELAY)) begin
      avProg_next = pwdata[9:0];
    end
  end

  // Millisecond timebase
  always_comb begin
    pre_next    = pre_reg + 15'h0001;
    msTick_next = 1'b0;
    if (pre_reg == 15'(TICK_CYCLES - 1)) begin
      pre_next    = 15'h0000;
      msTick_next = 1'b1;
    end
  end

  // Rate-dependent long AV delay
  always_comb begin
    rateDiff = rateBpm - `RATE_KNEE_BPM;
    stepMul  = {4'h0, rateDiff[7:2]} * `AV_STEP_MS;
    if (rateBpm <= `RATE_KNEE_BPM) begin
      extAv = `AV_LONG_MS;
    end else if (rateBpm >= `RATE_TOP_BPM) begin
      extAv = `AV_FLOOR_MS;
    end else begin
      extAv = `AV_LONG_MS - stepMul;
    end
    avShort = (avProg_reg < extAv) ? avProg_reg : extAv;
  end

  // Mode controller
  always_comb begin
    enabled  = ctrl_reg[`CTRL_EN_BIT];
    suspend  = !enabled || higherPrioritySuspend;
    vsNeeded = ctrl_reg[`CTRL_VS_MSB:`CTRL_VS_LSB];
    xNeeded  = {1'b0, ctrl_reg[`CTRL_X_MSB:`CTRL_X_LSB]};
    seen     = vsFlag_reg || ventricularSensedEvent;

    state_next      = state_reg;
    waitTarget_next = waitTarget_reg;
    consec_next     = consec_reg;
    searchCyc_next  = searchCyc_reg;
    missRun_next    = missRun_reg;
    switchCnt_next  = switchCnt_reg;
    lock_next       = lock_reg;
    failCnt_next    = failCnt_reg;
    fallback_next   = fallback_reg && !cycleEnd;
    restart         = 1'b0;
    waitClr         = 1'b0;
    gapClr          = ventricularSensedEvent;
    hourClr         = (hourCnt >= `HOUR_MS);
    hbus.shift      = 1'b0;
    hbus.miss       = 1'b0;
    hbus.clear      = 1'b0;
    fallbackNow     = 1'b0;

    // Sense flag: a new sense wins over the cycle-end clear
    vsFlag_next = ventricularSensedEvent || (vsFlag_reg && !cycleEnd);

    if (hourClr) begin
      switchCnt_next = 4'h0;
    end
    if (midnight) begin
      lock_next = 1'b0;
    end

    case (state_reg)
      ST_OFF: begin
        if (!suspend) begin
          state_next = ST_DDD;
          restart    = 1'b1;
        end
      end
      ST_DDD: begin
        if (!lock_reg && ventricularSensedEvent) begin
          state_next = ST_SEARCH;
        end else if (!lock_reg && (waitCnt >= waitTarget_reg)) begin
          state_next = ST_SEARCH;
        end
        consec_next    = 4'h0;
        searchCyc_next = 4'h0;
      end
      ST_SEARCH: begin
        if (cycleEnd) begin
          consec_next    = seen ? consec_reg + 4'h1 : 4'h0;
          searchCyc_next = searchCyc_reg + 4'h1;
          if (seen && ((consec_reg + 4'h1) >= vsNeeded)) begin
            state_next      = ST_ADI;
            waitTarget_next = `WAIT_FIRST_MS;
            hbus.clear      = 1'b1;
            missRun_next    = 2'h0;
            gapClr          = 1'b1;
          end else if ((searchCyc_reg + 4'h1) >= `SEARCH_CYCLES) begin
            state_next   = ST_DDD;
            waitClr      = 1'b1;
            failCnt_next = failCnt_reg + 16'h0001;
            if (waitTarget_reg >= `WAIT_MAX_MS) begin
              waitTarget_next = `WAIT_LONG_MS;
            end else begin
              waitTarget_next = {waitTarget_reg[30:0], 1'b0};
            end
          end
        end
      end
      ST_ADI: begin
        if (cycleEnd) begin
          hbus.shift   = 1'b1;
          hbus.miss    = !seen;
          missRun_next = seen ? 2'h0 : missRun_reg + 2'h1;
        end
        // Criteria evaluated side by side; any one switches
        if (gapCnt >= `VS_GAP_MS) begin
          fallbackNow = 1'b1;
        end
        if (cycleEnd && !seen && ((missRun_reg + 2'h1) >= `MISS_RUN)) begin
          fallbackNow = 1'b1;
        end
        if ((xNeeded != 4'h0) && (hbus.missCount >= xNeeded)) begin
          fallbackNow = 1'b1;
        end
        if (fallbackNow) begin
          state_next    = ST_DDD;
          fallback_next = 1'b1;
          waitClr       = 1'b1;
          if (!hourClr && (switchCnt_reg >= (`SWITCH_LIMIT - 4'h1))) begin
            lock_next      = 1'b1;
            switchCnt_next = 4'h0;
          end else begin
            switchCnt_next = hourClr ? 4'h1 : switchCnt_reg + 4'h1;
          end
        end
      end
      ST_DDI: begin
        if (resyncMet) begin
          state_next = ST_DDD;
          waitClr    = 1'b1;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase

    // Tachycardia mode switch overrides any suppression state
    if ((state_reg != ST_OFF) && (state_reg != ST_DDI) && modeSwitchMet) begin
      state_next = ST_DDI;
    end
    if (suspend) begin
      state_next = ST_OFF;
    end

    if (restart || headRemoved) begin
      waitTarget_next = `WAIT_FIRST_MS;
      waitClr         = 1'b1;
    end
    if (restart) begin
      consec_next    = 4'h0;
      searchCyc_next = 4'h0;
      missRun_next   = 2'h0;
      switchCnt_next = 4'h0;
      failCnt_next   = 16'h0000;
      hbus.clear     = 1'b1;
      hourClr        = 1'b1;
    end
  end

  // Output values follow the next state, except atrial pace enable, which is the inverse of intrinsicAboveRate
  always_comb begin
    supp_next  = (state_next == ST_DDD) || (state_next == ST_SEARCH) || (state_next == ST_ADI);
    vPace_next = (state_next != ST_ADI);
    aPace_next = !intrinsicAboveRate;
    ddi_next   = (state_next == ST_DDI);
    case (state_next)
      ST_SEARCH: avOut_next = extAv;
      ST_ADI:    avOut_next = extAv;
      ST_DDD:    avOut_next = fallback_next ? avShort : avProg_reg;
      default:   avOut_next = avProg_reg;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg       <= `CTRL_RESET;
      avProg_reg     <= `AVDELAY_RESET;
      prdata_reg     <= 32'h0000_0000;
      pready_reg     <= 1'b0;
      pslverr_reg    <= 1'b0;
      state_reg      <= ST_OFF;
      pre_reg        <= 15'h0000;
      msTick_reg     <= 1'b0;
      waitTarget_reg <= `WAIT_FIRST_MS;
      vsFlag_reg     <= 1'b0;
      consec_reg     <= 4'h0;
      searchCyc_reg  <= 4'h0;
      missRun_reg    <= 2'h0;
      switchCnt_reg  <= 4'h0;
      lock_reg       <= 1'b0;
      failCnt_reg    <= 16'h0000;
      fallback_reg   <= 1'b0;
      supp_reg       <= 1'b0;
      vPace_reg      <= 1'b1;
      aPace_reg      <= 1'b1;
      avOut_reg      <= `AVDELAY_RESET;
      ddi_reg        <= 1'b0;
    end else begin
      ctrl_reg       <= ctrl_next;
      avProg_reg     <= avProg_next;
      prdata_reg     <= prdata_next;
      pready_reg     <= pready_next;
      pslverr_reg    <= pslverr_next;
      state_reg      <= state_next;
      pre_reg        <= pre_next;
      msTick_reg     <= msTick_next;
      waitTarget_reg <= waitTarget_next;
      vsFlag_reg     <= vsFlag_next;
      consec_reg     <= consec_next;
      searchCyc_reg  <= searchCyc_next;
      missRun_reg    <= missRun_next;
      switchCnt_reg  <= switchCnt_next;
      lock_reg       <= lock_next;
      failCnt_reg    <= failCnt_next;
      fallback_reg   <= fallback_next;
      supp_reg       <= supp_next;
      vPace_reg      <= vPace_next;
      aPace_reg      <= aPace_next;
      avOut_reg      <= avOut_next;
      ddi_reg        <= ddi_next;
    end
  end

  assign prdata                = prdata_reg;
  assign pready                = pready_reg;
  assign pslverr               = pslverr_reg;
  assign suppressionActive     = supp_reg;
  assign ventricularPaceEnable = vPace_reg;
  assign atrialPaceEnable      = aPace_reg;
  assign avDelayMs             = avOut_reg;
  assign ddiActive             = ddi_reg;
  assign modeState             = state_reg;
endmodule

// ===== src/vps_regs.svh
// Purpose: Offsets, field positions, reset values and timing figures of the suppression block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Times are kept in their own unit; cycle counts are derived in the code
`ifndef VPS_REGS_SVH
`define VPS_REGS_SVH

// Register byte offsets
`define OFS_CTRL        12'h000
`define OFS_AVDELAY     12'h004
`define OFS_STATUS      12'h008
`define OFS_SCHED       12'h00c
`define OFS_COUNTS      12'h010

// Control fields
`define CTRL_EN_BIT     0
`define CTRL_RATE_BIT   1
`define CTRL_X_LSB      4
`define CTRL_X_MSB      6
`define CTRL_VS_LSB     8
`define CTRL_VS_MSB     11
`define CTRL_WMASK      32'h0000_0f73
`define CTRL_RESET      32'h0000_0330
`define AVDELAY_RESET   10'h096

// Status fields
`define STAT_LOCK_BIT   8
`define STAT_MISS_LSB   12

// Timebase: one millisecond tick from the 40 ns clock
`define TICK_NS         32'h000f_4240
`define CLK_NS          32'h0000_0028

// Timing in milliseconds
`define WAIT_FIRST_MS   32'h0000_7530
`define WAIT_MAX_MS     32'h0075_3000
`define WAIT_LONG_MS    32'h044a_a200
`define VS_GAP_MS       22'h0007d0
`define HOUR_MS         22'h36ee80

// AV delays in milliseconds and rate corners in bpm
`define AV_LONG_MS      10'h1c2
`define AV_FLOOR_MS     10'h12c
`define AV_STEP_MS      10'h00f
`define RATE_KNEE_BPM   8'h64
`define RATE_TOP_BPM    8'h8c

// Cycle counts and mode-switch limit
`define SEARCH_CYCLES   4'h8
`define MISS_RUN        2'h2
`define SWITCH_LIMIT    4'hf

`endif

// ===== src/vps_pkg.sv
// Purpose: Types shared by the suppression block
// Assumes: Nothing
// Notes:   State codes are one-hot
package vps_pkg;

  typedef enum logic [4:0] {
    ST_OFF    = 5'h01,
    ST_DDD    = 5'h02,
    ST_SEARCH = 5'h04,
    ST_ADI    = 5'h08,
    ST_DDI    = 5'h10
  } vps_state_t;

endpackage

// ===== src/history_if.sv
// Purpose: Carries the per-cycle miss history between controller and history window
// Assumes: One shift pulse per cardiac cycle
// Notes:   missCount is registered in the window module
interface history_if;
  logic       shift;
  logic       miss;
  logic       clear;
  logic [3:0] missCount;

  modport hist (input shift, input miss, input clear, output missCount);
  modport user (output shift, output miss, output clear, input missCount);
endinterface

// ===== src/vps_ms_counter.sv
// Purpose: Saturating millisecond counter with clear
// Assumes: tick is a one-cycle pulse
// Notes:   Clear wins over a tick in the same cycle
module vps_ms_counter #(
  parameter int W = 32
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         clear,
  input  wire logic         tick,
  output logic [W-1:0]      count
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (clear) begin
      count_next = '0;
    end else if (tick && (count_reg != {W{1'b1}})) begin
      count_next = count_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
endmodule

// ===== src/vps_cycle_history.sv
// Purpose: Fixed eight-cycle window of cycles lacking a ventricular sense
// Assumes: shift pulses once per cardiac cycle
// Notes:   Window length is not adjustable
module vps_cycle_history (
  input  wire logic core_clk,
  input  wire logic rst,
  history_if.hist   hist
);
  logic [7:0] win_reg;
  logic [7:0] win_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;

  always_comb begin
    win_next = win_reg;
    if (hist.clear) begin
      win_next = 8'h00;
    end else if (hist.shift) begin
      win_next = {win_reg[6:0], hist.miss};
    end
    cnt_next = 4'h0;
    for (int i = 0; i < 8; i++) begin
      cnt_next = cnt_next + {3'h0, win_next[i]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      win_reg <= 8'h00;
      cnt_reg <= 4'h0;
    end else begin
      win_reg <= win_next;
      cnt_reg <= cnt_next;
    end
  end

  assign hist.missCount = cnt_reg;
endmodule

// ===== tb/vps_properties.sv
// Purpose: Port-level checks of the suppression controller
// Assumes: Bound to the top module
// Notes:   Lock and timer criteria are judged by the bench
module vps_properties
  import vps_pkg::*;
#(
  parameter int TICK_CYCLES = 2
) (
  input logic       core_clk,
  input logic       rst,
  input logic       psel,
  input logic       penable,
  input logic       pwrite,
  input logic       cycleEnd,
  input logic       ventricularSensedEvent,
  input logic       intrinsicAboveRate,
  input logic [7:0] rateBpm,
  input logic       modeSwitchMet,
  input logic       resyncMet,
  input logic       higherPrioritySuspend,
  input logic       suppressionActive,
  input logic       ventricularPaceEnable,
  input logic       atrialPaceEnable,
  input logic [9:0] avDelayMs,
  input logic       ddiActive,
  input logic [4:0] modeState
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic       wr;
  logic       seenFlag;
  logic [1:0] missRun;
  assign wr = psel && penable && pwrite;
  // Run of ADI cycles closed without a ventricular sense
  always_ff @(posedge core_clk) begin
    if (rst || modeState != ST_ADI) begin
      seenFlag <= 1'b0;
      missRun  <= 2'h0;
    end else if (cycleEnd) begin
      seenFlag <= 1'b0;
      if (seenFlag || ventricularSensedEvent) missRun <= 2'h0;
      else if (missRun != 2'h3) missRun <= missRun + 2'h1;
    end else if (ventricularSensedEvent) begin
      seenFlag <= 1'b1;
    end
  end
  sequence s_tachyMet;
    modeSwitchMet && !higherPrioritySuspend && !wr
      && modeState inside {ST_DDD, ST_SEARCH, ST_ADI};
  endsequence
  sequence s_leaveOff;
    modeState == ST_OFF ##1 modeState != ST_OFF;
  endsequence
  property p_ventPace;
    ventricularPaceEnable == (modeState != ST_ADI);
  endproperty
  property p_atrial;
    !$past(rst) |-> atrialPaceEnable == !$past(intrinsicAboveRate);
  endproperty
  property p_longDelay;
    modeState inside {ST_SEARCH, ST_ADI} && rateBpm <= 8'h64 && $past(rateBpm) <= 8'h64
      |-> avDelayMs == 10'h1c2;
  endproperty
  property p_miss2;
    missRun == 2'h2 |-> ##[0:2] modeState != ST_ADI;
  endproperty
  property p_ddiEntry;
    s_tachyMet |=> modeState == ST_DDI && ddiActive && !suppressionActive;
  endproperty
  property p_resync;
    modeState == ST_DDI && resyncMet && !modeSwitchMet && !higherPrioritySuspend && !wr
      |=> modeState == ST_DDD;
  endproperty
  property p_noDdiToAdi;
    modeState == ST_DDI |=> modeState inside {ST_DDI, ST_DDD, ST_OFF};
  endproperty
  property p_suspend;
    higherPrioritySuspend |=> modeState == ST_OFF && !suppressionActive;
  endproperty
  property p_resume;
    s_leaveOff |-> modeState == ST_DDD;
  endproperty
  property p_adiFromSearch;
    $rose(modeState == ST_ADI) |-> $past(modeState) == ST_SEARCH;
  endproperty
  a_ventPace: assert property (p_ventPace)
    else $error("pace enable disagrees with state");
  a_atrial: assert property (p_atrial)
    else $error("atrial pace enable wrong");
  a_longDelay: assert property (p_longDelay)
    else $error("long delay wrong");
  a_miss2: assert property (p_miss2)
    else $error("no fallback after two missed cycles");
  a_ddiEntry: assert property (p_ddiEntry)
    else $error("no entry to DDI");
  a_resync: assert property (p_resync)
    else $error("no return to DDD");
  a_noDdiToAdi: assert property (p_noDdiToAdi)
    else $error("illegal exit from DDI");
  a_suspend: assert property (p_suspend)
    else $error("suspend ignored");
  a_resume: assert property (p_resume)
    else $error("resume not in DDD");
  a_adiFromSearch: assert property (p_adiFromSearch)
    else $error("ADI entered without search");
endmodule

bind ventricular_pacing_suppression vps_properties #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .core_clk, .rst, .psel, .penable, .pwrite, .cycleEnd, .ventricularSensedEvent,
  .intrinsicAboveRate, .rateBpm, .modeSwitchMet, .resyncMet, .higherPrioritySuspend,
  .suppressionActive, .ventricularPaceEnable, .atrialPaceEnable, .avDelayMs, .ddiActive,
  .modeState);

// ===== tb/sense_channel_model.sv
// Purpose: Cardiac sense channels, one beat per call
// Assumes: Caller enters just after a rising edge
// Notes:   Sense pulse precedes the cycle-end pulse
module sense_channel_model (
  input  logic core_clk,
  output logic cycleEnd,
  output logic ventricularSensedEvent
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cycleEnd = 1'b0;
    ventricularSensedEvent = 1'b0;
  end
  task automatic beat(input logic vs);
    repeat (4) @(posedge core_clk);
    ventricularSensedEvent <= vs;
    @(posedge core_clk);
    ventricularSensedEvent <= 1'b0;
    cycleEnd <= 1'b1;
    @(posedge core_clk);
    cycleEnd <= 1'b0;
  endtask
endmodule

// ===== tb/ventricular_pacing_suppression_bench.sv
// Purpose: Self-checking bench of the suppression controller
// Assumes: Millisecond tick shortened to two clocks
// Notes:   Rate rows first, then hand-written cases
`include "vps_regs.svh"
module ventricular_pacing_suppression_bench
  import vps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] rate; logic [9:0] av;} row_t;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic        cycleEnd, vsEvent, intrinsicAboveRate, headRemoved, modeSwitchMet;
  logic        resyncMet, higherPrioritySuspend, midnight, suppressionActive;
  logic        ventricularPaceEnable, atrialPaceEnable, ddiActive;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  rateBpm;
  logic [9:0]  avDelayMs;
  logic [4:0]  modeState;
  int          errors;
  int          checksDone;
  row_t        rows [7] = '{'{8'h46, 10'h1c2}, '{8'h64, 10'h1c2}, '{8'h68, 10'h1b3},
    '{8'h78, 10'h177}, '{8'h8b, 10'h13b}, '{8'h8c, 10'h12c}, '{8'hc8, 10'h12c}};

  ventricular_pacing_suppression #(.TICK_CYCLES(2)) dut_u (
    .core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .cycleEnd, .ventricularSensedEvent(vsEvent), .intrinsicAboveRate,
    .rateBpm, .headRemoved, .modeSwitchMet, .resyncMet, .higherPrioritySuspend,
    .midnight, .suppressionActive, .ventricularPaceEnable, .atrialPaceEnable,
    .avDelayMs, .ddiActive, .modeState);
  sense_channel_model chan_u (.core_clk, .cycleEnd, .ventricularSensedEvent(vsEvent));

  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic st(input vps_state_t s);
    chk("modeState", 32'(s), 32'(modeState));
  endtask
  task automatic beats(input int n, input logic vs);
    repeat (n) chan_u.beat(vs);
    tk(3);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    tk(80000);
    errors++;
    $display("ERROR watchdog expected finish seen timeout");
    results();
  end

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {intrinsicAboveRate, headRemoved, modeSwitchMet, resyncMet} = '0;
    {higherPrioritySuspend, midnight} = '0;
    rateBpm = 8'h46;
    errors = 0;
    checksDone = 0;
    tk(8);
    rst <= 1'b0;
    apb(1'b1, `OFS_AVDELAY, 32'h0000_00c8);
    apb(1'b1, `OFS_CTRL, 32'h0000_0231);
    tk(2);
    st(ST_DDD);
    chk("avDelayMs", 32'h0c8, 32'(avDelayMs));
    beats(1, 1'b1);
    st(ST_SEARCH);
    foreach (rows[i]) begin
      rateBpm <= rows[i].rate;
      tk(3);
      chk("avDelayMs", 32'(rows[i].av), 32'(avDelayMs));
    end
    rateBpm <= 8'h46;
    $display("test rate rows done");
    beats(2, 1'b1);
    st(ST_ADI);
    chk("ventricularPaceEnable", 32'h0, 32'(ventricularPaceEnable));
    beats(2, 1'b0);
    st(ST_DDD);
    chk("avDelayMs", 32'h0c8, 32'(avDelayMs));
    $display("test search and fallback done");
    for (int k = 0; k < 2; k++) begin
      beats(1, 1'b1);
      st(ST_SEARCH);
      beats(8, 1'b0);
      st(ST_DDD);
      chk("avDelayMs", 32'h0c8, 32'(avDelayMs));
      chk("suppressionActive", 32'h1, 32'(suppressionActive));
      apb(1'b0, `OFS_SCHED, 32'h0);
      chk("sched", 32'd60000 << k, rd);
    end
    headRemoved <= 1'b1;
    tk(1);
    headRemoved <= 1'b0;
    apb(1'b0, `OFS_SCHED, 32'h0);
    chk("sched", 32'd30000, rd);
    $display("test failed searches done");
    apb(1'b1, `OFS_CTRL, 32'h0000_0230);
    tk(2);
    st(ST_OFF);
    apb(1'b1, `OFS_CTRL, 32'h0000_0231);
    tk(2);
    st(ST_DDD);
    apb(1'b0, `OFS_SCHED, 32'h0);
    chk("sched", 32'd30000, rd);
    tk(59900);
    st(ST_DDD);
    tk(200);
    st(ST_SEARCH);
    beats(3, 1'b1);
    st(ST_ADI);
    beats(1, 1'b0);
    beats(1, 1'b1);
    beats(1, 1'b0);
    beats(1, 1'b1);
    st(ST_ADI);
    beats(1, 1'b0);
    st(ST_DDD);
    $display("test x of eight done");
    beats(3, 1'b1);
    st(ST_ADI);
    intrinsicAboveRate <= 1'b1;
    tk(3);
    chk("atrialPaceEnable", 32'h0, 32'(atrialPaceEnable));
    intrinsicAboveRate <= 1'b0;
    tk(3950);
    st(ST_ADI);
    tk(70);
    st(ST_DDD);
    $display("test two second timer done");
    beats(1, 1'b1);
    modeSwitchMet <= 1'b1;
    tk(1);
    modeSwitchMet <= 1'b0;
    tk(2);
    st(ST_DDI);
    chk("ddiActive", 32'h1, 32'(ddiActive));
    resyncMet <= 1'b1;
    tk(1);
    resyncMet <= 1'b0;
    tk(2);
    st(ST_DDD);
    higherPrioritySuspend <= 1'b1;
    tk(3);
    st(ST_OFF);
    higherPrioritySuspend <= 1'b0;
    tk(3);
    st(ST_DDD);
    $display("test priority done");
    for (int k = 0; k < 15; k++) begin
      beats(2, 1'b1);
      beats(2, 1'b0);
    end
    st(ST_DDD);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("lock", 32'h1, 32'(rd[`STAT_LOCK_BIT]));
    beats(1, 1'b1);
    st(ST_DDD);
    midnight <= 1'b1;
    tk(1);
    midnight <= 1'b0;
    beats(1, 1'b1);
    st(ST_SEARCH);
    $display("test switch lock done");
    rst <= 1'b1;
    tk(2);
    rst <= 1'b0;
    tk(2);
    st(ST_OFF);
    chk("avDelayMs", 32'(`AVDELAY_RESET), 32'(avDelayMs));
    chk("ventricularPaceEnable", 32'h1, 32'(ventricularPaceEnable));
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl", `CTRL_RESET, rd);
    apb(1'b0, 12'h020, 32'h0);
    chk("pslverr", 32'h1, 32'(er));
    chk("prdata", 32'h0, rd);
    $display("test reset done");
    results();
  end
endmodule
